// ==== hw/ftog_pkg.sv ====
// shared constants and carrier types of the frame trigger overlap gate
package ftog_pkg;
   // ---------------------------------------------------------------
   // clock and timing
   // ---------------------------------------------------------------
   localparam int CLK_NS = 40;
   localparam int US_CYC = 1000 / CLK_NS;
   localparam logic [4:0] TICK_LAST = 5'(US_CYC - 1);
   localparam int TRIG_EXP_NS = 3230;
   localparam int TRIG_EXP_CYC = (TRIG_EXP_NS + CLK_NS - 1) / CLK_NS;
   localparam int TAIL_NS = 16500;
   localparam int TAIL_CYC = (TAIL_NS + CLK_NS - 1) / CLK_NS;
   localparam int GAP_NS = 62000;
   localparam int GAP_CYC = (GAP_NS + CLK_NS - 1) / CLK_NS;
   localparam int READOUT_MAX_US = 23242;
   localparam int READOUT_MIN_US = 1602;
   localparam int LINE_HOLD = 12;
   localparam int CW = 24;
   // ---------------------------------------------------------------
   // register map (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_EXPOSE = 8'h04;
   localparam logic [7:0] A_DEBOUNCE = 8'h08;
   localparam logic [7:0] A_SOFT = 8'h0c;
   localparam logic [7:0] A_STATUS = 8'h10;
   localparam logic [7:0] A_COUNT = 8'h14;
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam logic [CW-1:0] EXPOSE_RST = 24'h00_0100;
   localparam logic [7:0] DEBOUNCE_RST = 8'h00;
   // ---------------------------------------------------------------
   // field encodings
   // ---------------------------------------------------------------
   localparam logic [1:0] POL_OFF = 2'h0;
   localparam logic [1:0] POL_READOUT = 2'h1;
   localparam logic [1:0] POL_EXP_CLOSE = 2'h2;
   localparam logic [2:0] SRC_LINE1 = 3'h0;
   localparam logic [2:0] SRC_LINE2 = 3'h1;
   localparam logic [2:0] SRC_SOFT = 3'h2;
   localparam logic [2:0] SRC_TIMER = 3'h3;
   localparam logic [2:0] SRC_COUNTER = 3'h4;
   // ---------------------------------------------------------------
   // carriers
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [22:0] rsvd;
      logic [2:0] start_event_select;
      logic start_edge_select;
      logic shutter_timing_select;
      logic sensor_family;
      logic [1:0] frame_accept_policy;
      logic external_start_enable;
   } ftog_ctrl_t;
   typedef struct packed {
      logic [1:0] line;
      logic timer_end;
      logic counter_end;
   } ftog_trig_in_t;
   typedef struct packed {
      logic exposure;
      logic readout;
      logic frame_active;
      logic accepted;
      logic rejected;
   } ftog_seq_t;
endpackage

// ==== hw/ftog_dbnc.sv ====
// debounce filter for one trigger input line
`timescale 1ns/1ns
`default_nettype none
module ftog_dbnc import ftog_pkg::*; (
   input wire logic pclk, // clock
   input wire logic presetn, // async reset, active low
   input wire logic raw, // line level in
   input wire logic [7:0] period_us, // filter time in microseconds
   output logic clean // filtered level
);
   typedef struct packed {
      logic [4:0] tick;
      logic [7:0] us;
      logic clean;
   } ftog_dbnc_t;
   ftog_dbnc_t s;
   ftog_dbnc_t next_s;
   always_comb begin
      next_s = s;
      if (raw == s.clean) begin
         // a glitch shorter than the period restarts the measure
         next_s.tick = 5'h0;
         next_s.us = 8'h00;
      end else if (s.us >= period_us) begin
         next_s.clean = raw;
      end else if (s.tick == TICK_LAST) begin
         next_s.tick = 5'h0;
         next_s.us = s.us + 8'h01;
      end else begin
         next_s.tick = s.tick + 5'h1;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end
   assign clean = s.clean;
endmodule
`default_nettype wire

// ==== hw/ftog_down.sv ====
// loadable down counter with registered busy flag
`timescale 1ns/1ns
`default_nettype none
module ftog_down #(
   parameter int W = 24
) (
   input wire logic pclk, // clock
   input wire logic presetn, // async reset, active low
   input wire logic load, // load value this cycle
   input wire logic [W-1:0] value, // cycles to run
   output logic [W-1:0] count, // cycles left
   output logic busy // count not zero
);
   typedef struct packed {
      logic [W-1:0] count;
      logic busy;
   } ftog_down_t;
   ftog_down_t s;
   ftog_down_t next_s;
   always_comb begin
      next_s = s;
      if (load) begin
         next_s.count = value;
         next_s.busy = (value != '0);
      end else if (s.count != '0) begin
         next_s.count = s.count - W'(1);
         next_s.busy = (s.count > W'(1));
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end
   assign count = s.count;
   assign busy = s.busy;
endmodule
`default_nettype wire

// ==== hw/ftog_gate.sv ====
// frame trigger acceptance and exposure/readout sequencing with APB registers
//
// Register access over APB and the register offsets were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module ftog_gate import ftog_pkg::*; #(
   parameter int READOUT_CYC = READOUT_MAX_US * US_CYC,
   parameter int LINE_CYC = 10
) (
   input wire logic pclk, // clock, 25 MHz
   input wire logic presetn, // async reset, active low
   input wire logic psel, // apb select
   input wire logic penable, // apb enable
   input wire logic pwrite, // apb direction
   input wire logic [7:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error
   input wire ftog_trig_in_t trig_in, // trigger sources
   output ftog_seq_t seq // sequencer controls
);
   // ---------------------------------------------------------------
   // types and constants
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      FS_IDLE,
      FS_WAIT,
      FS_EXPOSE
   } ftog_fsm_t;

   typedef struct packed {
      ftog_fsm_t fsm;
      ftog_ctrl_t ctrl;
      logic [CW-1:0] exp_time;
      logic [7:0] dbnc_us;
      logic sw_pulse;
      logic src_prev;
      logic rd_pend;
      logic exposure;
      logic frame_active;
      logic accepted;
      logic rejected;
      logic [15:0] n_acc;
      logic [15:0] n_rej;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } ftog_state_t;

   localparam logic [CW-1:0] RD_LOAD = CW'(READOUT_CYC + TAIL_CYC);
   localparam logic [CW-1:0] OFF_A_DLY = CW'(TRIG_EXP_CYC);
   // second family has no fixed start latency with overlap off
   localparam logic [CW-1:0] OFF_B_DLY = 24'h00_0001;
   localparam logic [CW-1:0] GAP_DLY = CW'(GAP_CYC);
   localparam logic [CW-1:0] HOLD_DLY = CW'(LINE_HOLD * LINE_CYC);

   // ---------------------------------------------------------------
   // functions
   // ---------------------------------------------------------------
   function automatic logic addr_ok(input logic [7:0] a);
      addr_ok = (a == A_CTRL) || (a == A_EXPOSE) || (a == A_DEBOUNCE) ||
                (a == A_SOFT) || (a == A_STATUS) || (a == A_COUNT);
   endfunction

   // delay between acceptance and the earliest exposure start
   function automatic logic [CW-1:0] first_delay(input logic [1:0] pol,
                                                  input logic fam_b);
      if (pol == POL_OFF) begin
         first_delay = fam_b ? OFF_B_DLY : OFF_A_DLY;
      end else if (fam_b) begin
         first_delay = HOLD_DLY;
      end else if (pol == POL_READOUT) begin
         first_delay = GAP_DLY;
      end else begin
         first_delay = '0;
      end
   endfunction

   // ---------------------------------------------------------------
   // state and submodules
   // ---------------------------------------------------------------
   ftog_state_t s;
   ftog_state_t next_s;
   logic [1:0] line_db;
   logic dly_load;
   logic [CW-1:0] dly_val;
   logic [CW-1:0] dly_cnt;
   logic dly_busy;
   logic rd_load;
   logic [CW-1:0] rd_cnt;
   logic rd_busy;
   logic exp_load;
   logic [CW-1:0] exp_cnt;
   logic exp_busy;

   for (genvar i = 0; i < 2; i++) begin : g_line
      ftog_dbnc u_dbnc (
         .pclk(pclk),
         .presetn(presetn),
         .raw(trig_in.line[i]),
         .period_us(s.dbnc_us),
         .clean(line_db[i])
      );
   end

   // start delay, gap and line-clock hold
   ftog_down #(.W(CW)) u_dly (
      .pclk(pclk),
      .presetn(presetn),
      .load(dly_load),
      .value(dly_val),
      .count(dly_cnt),
      .busy(dly_busy)
   );

   // readout of the frame in flight
   ftog_down #(.W(CW)) u_rd (
      .pclk(pclk),
      .presetn(presetn),
      .load(rd_load),
      .value(RD_LOAD),
      .count(rd_cnt),
      .busy(rd_busy)
   );

   // timed exposure length
   ftog_down #(.W(CW)) u_exp (
      .pclk(pclk),
      .presetn(presetn),
      .load(exp_load),
      .value(s.exp_time),
      .count(exp_cnt),
      .busy(exp_busy)
   );

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   logic lvl;
   logic evt;
   logic win;
   logic a_ro;
   logic aligned;
   logic go;
   logic done;
   logic setup;
   logic wr;

   always_comb begin
      next_s = s;
      lvl = 1'b0;
      evt = 1'b0;
      win = 1'b0;
      a_ro = 1'b0;
      aligned = 1'b0;
      go = 1'b0;
      done = 1'b0;
      dly_load = 1'b0;
      dly_val = '0;
      rd_load = 1'b0;
      exp_load = 1'b0;
      setup = psel && !penable;
      wr = psel && penable && pwrite && s.pready;
      next_s.sw_pulse = 1'b0;
      next_s.accepted = 1'b0;
      next_s.rejected = 1'b0;

      // apb: no wait states, answer in the access cycle
      next_s.pready = setup;
      next_s.pslverr = setup && !addr_ok(paddr);
      next_s.prdata = 32'h0000_0000;
      if (setup && !pwrite) begin
         case (paddr)
            A_CTRL: next_s.prdata = s.ctrl;
            A_EXPOSE: next_s.prdata = {8'h00, s.exp_time};
            A_DEBOUNCE: next_s.prdata = {24'h00_0000, s.dbnc_us};
            A_STATUS: next_s.prdata = {26'h000_0000, s.fsm, s.rd_pend,
                                       rd_busy, s.exposure, s.frame_active};
            A_COUNT: next_s.prdata = {s.n_rej, s.n_acc};
            default: next_s.prdata = 32'h0000_0000;
         endcase
      end
      if (wr) begin
         case (paddr)
            A_CTRL: next_s.ctrl = ftog_ctrl_t'({23'h00_0000, pwdata[8:0]});
            A_EXPOSE: next_s.exp_time = pwdata[CW-1:0];
            A_DEBOUNCE: next_s.dbnc_us = pwdata[7:0];
            A_SOFT: next_s.sw_pulse = pwdata[0];
            default: next_s.sw_pulse = 1'b0;
         endcase
      end

      // trigger source and edge
      case (s.ctrl.start_event_select)
         SRC_LINE1: lvl = line_db[0] ^ s.ctrl.start_edge_select;
         SRC_LINE2: lvl = line_db[1] ^ s.ctrl.start_edge_select;
         SRC_SOFT: lvl = s.sw_pulse;
         SRC_TIMER: lvl = trig_in.timer_end;
         SRC_COUNTER: lvl = trig_in.counter_end;
         default: lvl = 1'b0;
      endcase
      next_s.src_prev = lvl;
      // a control write re-arms the detector, so a new edge select
      // cannot fake an edge on an idle line
      if (wr && paddr == A_CTRL) begin
         next_s.src_prev = 1'b1;
      end
      evt = lvl && !s.src_prev && s.ctrl.external_start_enable;

      // acceptance window while idle
      case (s.ctrl.frame_accept_policy)
         POL_OFF: win = !rd_busy && !s.rd_pend;
         POL_READOUT: win = !s.rd_pend;
         POL_EXP_CLOSE: win = 1'b1;
         default: win = 1'b0;
      endcase
      // first family with the readout policy never overlaps: it waits out the readout, then the gap
      a_ro = !s.ctrl.sensor_family && (s.ctrl.frame_accept_policy == POL_READOUT);
      // short exposure waits so that it closes with the running readout
      aligned = s.ctrl.shutter_timing_select ||
                (!s.rd_pend && (!rd_busy || rd_cnt <= s.exp_time));

      // pending readout starts as soon as the previous one ends
      if (s.rd_pend && !rd_busy) begin
         rd_load = 1'b1;
         next_s.rd_pend = 1'b0;
      end

      case (s.fsm)
         FS_IDLE: begin
            if (evt && win) begin
               next_s.fsm = FS_WAIT;
               dly_load = 1'b1;
               dly_val = first_delay(s.ctrl.frame_accept_policy,
                                     s.ctrl.sensor_family);
               next_s.accepted = 1'b1;
            end else if (evt) begin
               next_s.rejected = 1'b1;
            end
         end
         FS_WAIT: begin
            if (evt) begin
               next_s.rejected = 1'b1;
            end
            if (a_ro && (rd_busy || s.rd_pend)) begin
               // gap restarts until the previous readout is over
               dly_load = 1'b1;
               dly_val = GAP_DLY;
            end else if (!dly_busy) begin
               go = a_ro || aligned;
            end
            if (go) begin
               next_s.fsm = FS_EXPOSE;
               next_s.exposure = 1'b1;
               exp_load = 1'b1;
            end
         end
         FS_EXPOSE: begin
            if (evt) begin
               next_s.rejected = 1'b1;
            end
            if (s.ctrl.shutter_timing_select) begin
               // with the readout policy, pulse mode stays open until the previous readout is out
               done = !lvl;
               if (s.ctrl.frame_accept_policy == POL_READOUT && (rd_busy || s.rd_pend)) begin
                  done = 1'b0;
               end
            end else begin
               done = !exp_busy;
            end
            if (done) begin
               next_s.fsm = FS_IDLE;
               next_s.exposure = 1'b0;
               // a pending readout launched this cycle leaves the new
               // frame pending behind it, so set wins over clear
               if (rd_busy || s.rd_pend) begin
                  next_s.rd_pend = 1'b1;
               end else begin
                  rd_load = 1'b1;
               end
            end
         end
         default: begin
            next_s.fsm = FS_IDLE;
            next_s.exposure = 1'b0;
         end
      endcase

      if (next_s.accepted) begin
         next_s.n_acc = s.n_acc + 16'h0001;
      end
      if (next_s.rejected) begin
         next_s.n_rej = s.n_rej + 16'h0001;
      end
      next_s.frame_active = (next_s.fsm != FS_IDLE) || rd_busy ||
                            next_s.rd_pend || rd_load;
   end

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '0;
         s.fsm <= FS_IDLE;
         s.ctrl <= ftog_ctrl_t'(CTRL_RST);
         s.exp_time <= EXPOSE_RST;
         s.dbnc_us <= DEBOUNCE_RST;
      end else begin
         s <= next_s;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   // readout comes from the counter's own busy flop
   assign prdata = s.prdata;
   assign pready = s.pready;
   assign pslverr = s.pslverr;
   assign seq.exposure = s.exposure;
   assign seq.readout = rd_busy;
   assign seq.frame_active = s.frame_active;
   assign seq.accepted = s.accepted;
   assign seq.rejected = s.rejected;
endmodule
`default_nettype wire

// ==== verif/ftog_gate_assertions.sv ====
// assertion checker bound to the frame trigger overlap gate
`timescale 1ns/1ns
`default_nettype none
module ftog_chk import ftog_pkg::*; #(
   parameter int READOUT_CYC = 200,
   parameter int LINE_CYC = 2
) (
   input wire logic pclk, // clock
   input wire logic presetn, // async reset, active low
   input wire logic psel, // apb select
   input wire logic penable, // apb enable
   input wire logic pwrite, // apb direction
   input wire logic [7:0] paddr, // apb address
   input wire logic [31:0] pwdata, // apb write data
   input wire logic [31:0] prdata, // apb read data
   input wire logic pready, // apb ready
   input wire logic pslverr, // apb error
   input wire ftog_trig_in_t trig_in, // trigger sources
   input wire ftog_seq_t seq // sequencer controls
);
   ftog_ctrl_t cq;
   logic [15:0] acc_age;
   logic [15:0] rd_age;
   logic [15:0] rd_len;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // shadow control word, ages saturate so old frames never trip a check
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cq <= '0;
         acc_age <= 16'hffff;
         rd_age <= 16'hffff;
         rd_len <= 16'h0000;
      end else begin
         if (psel && penable && pready && pwrite && paddr == A_CTRL) begin
            cq <= ftog_ctrl_t'(pwdata);
         end
         if (seq.accepted) acc_age <= 16'h0000;
         else if (acc_age != 16'hffff) acc_age <= acc_age + 16'h0001;
         if (seq.readout) rd_age <= 16'h0000;
         else if (rd_age != 16'hffff) rd_age <= rd_age + 16'h0001;
         if (seq.readout) rd_len <= rd_len + 16'h0001;
         else rd_len <= 16'h0000;
      end
   end
   property p_ready;
      psel && !penable |=> pready;
   endproperty
   a_ready: assert property (p_ready) else $error("no ready after setup");
   property p_frame;
      seq.exposure || seq.readout |-> seq.frame_active;
   endproperty
   a_frame: assert property (p_frame) else $error("frame active low in frame");
   property p_exp_rd;
      $fell(seq.exposure) |-> ##[0:2] seq.readout;
   endproperty
   a_exp_rd: assert property (p_exp_rd) else $error("no readout after exposure");
   property p_off_drop;
      cq.frame_accept_policy == POL_OFF && seq.readout && $past(seq.readout, 2) |-> !seq.accepted;
   endproperty
   a_off_drop: assert property (p_off_drop) else $error("accepted during readout");
   property p_delay;
      $rose(seq.exposure) && cq.frame_accept_policy == POL_OFF && !cq.sensor_family && !cq.shutter_timing_select
         |-> acc_age inside {[76:88]};
   endproperty
   a_delay: assert property (p_delay) else $error("trigger to exposure delay");
   property p_rd_len;
      $fell(seq.readout) && cq.frame_accept_policy == POL_OFF |-> rd_len == 16'(READOUT_CYC + TAIL_CYC);
   endproperty
   a_rd_len: assert property (p_rd_len) else $error("readout length");
   property p_excl;
      seq.exposure && $past(seq.exposure, 2) |-> !seq.accepted;
   endproperty
   a_excl: assert property (p_excl) else $error("accepted during exposure");
   property p_gap;
      $rose(seq.exposure) && cq.frame_accept_policy == POL_READOUT && !cq.sensor_family
         |-> !seq.readout && rd_age >= 16'(GAP_CYC - 2);
   endproperty
   a_gap: assert property (p_gap) else $error("exposure too soon after readout");
   property p_enable;
      !cq.external_start_enable && !$past(cq.external_start_enable, 3) |-> !seq.accepted && !seq.rejected;
   endproperty
   a_enable: assert property (p_enable) else $error("trigger seen while disabled");
endmodule
bind ftog_gate ftog_chk #(.READOUT_CYC(READOUT_CYC), .LINE_CYC(LINE_CYC)) chk (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .trig_in(trig_in), .seq(seq));
`default_nettype wire

// ==== verif/ftog_src.sv ====
// trigger source model: input lines and internal end events
`timescale 1ns/1ns
`default_nettype none
module ftog_src import ftog_pkg::*; (
   input wire logic pclk, // clock
   output var ftog_trig_in_t trig_in // trigger sources to the gate
);
   initial trig_in = '0;
   // lines held w+1 cycles so the debounce filter sees a settled level
   task automatic fire(input logic [2:0] s, input int w);
      @(posedge pclk);
      case (s)
         SRC_LINE1: trig_in.line[0] <= 1'b1;
         SRC_LINE2: trig_in.line[1] <= 1'b1;
         SRC_TIMER: trig_in.timer_end <= 1'b1;
         SRC_COUNTER: trig_in.counter_end <= 1'b1;
         default: ;
      endcase
      @(posedge pclk);
      trig_in.timer_end <= 1'b0;
      trig_in.counter_end <= 1'b0;
      repeat (w) @(posedge pclk);
      trig_in.line <= 2'b00;
   endtask
endmodule
`default_nettype wire

// ==== verif/tb.sv ====
// self-checking bench for the frame trigger overlap gate
`timescale 1ns/1ns
`default_nettype none
module tb import ftog_pkg::*;;
   localparam int RD = 200;
   localparam int RL = RD + TAIL_CYC;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, re;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rq;
   ftog_trig_in_t trig_in;
   ftog_seq_t seq;
   int fails, tests_run, acc_n, rej_n, a0, r0, cyc, t0, ea_t, er_t;
   ftog_gate #(.READOUT_CYC(RD), .LINE_CYC(2)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .trig_in(trig_in), .seq(seq));
   ftog_src src (.pclk(pclk), .trig_in(trig_in));
   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cyc++;
      acc_n += int'(seq.accepted === 1'b1);
      rej_n += int'(seq.rejected === 1'b1);
   end
   // ---------------------------------------------------------------
   // tasks
   // ---------------------------------------------------------------
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         fails++;
         $display("unexpected %s: expected %h, seen %h", nm, e, g);
      end
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q, output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task pc(input int ea, input int er);
      repeat (4) @(posedge pclk);
      @(negedge pclk);
      chk("accepted", ea, acc_n - a0);
      chk("rejected", er, rej_n - r0);
      a0 = acc_n;
      r0 = rej_n;
      ea_t += ea;
      er_t += er;
   endtask
   task till(input int k, input logic v);
      int m;
      m = 0;
      do begin
         @(negedge pclk);
         m++;
      end while ((k == 0 ? seq.exposure : k == 1 ? seq.readout : seq.frame_active) !== v && m < 4000);
      chk("wait", 1, m < 4000);
   endtask
   function automatic logic [31:0] cw(input logic [1:0] p, input logic f, input logic [2:0] s);
      return {23'h00_0000, s, 2'b00, f, p, 1'b1};
   endfunction
   task results;
      $display("checks %0d, mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   initial begin
      #(30000 * 40);
      fails++;
      results;
   end
   // ---------------------------------------------------------------
   // tests
   // ---------------------------------------------------------------
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, A_CTRL, 32'h0000_0000, rq, re);
      chk("ctrl", CTRL_RST, rq);
      apb(1'b0, A_EXPOSE, 32'h0000_0000, rq, re);
      chk("expose", 32'(EXPOSE_RST), rq);
      apb(1'b0, A_DEBOUNCE, 32'h0000_0000, rq, re);
      chk("debounce", 32'(DEBOUNCE_RST), rq);
      apb(1'b0, 8'h18, 32'h0000_0000, rq, re);
      chk("slverr", 1, re);
      chk("unmapped", 0, rq);
      $display("test registers done");
      apb(1'b1, A_EXPOSE, 32'h0000_0014, rq, re);
      apb(1'b1, A_CTRL, cw(POL_OFF, 1'b0, SRC_LINE1), rq, re);
      src.fire(SRC_LINE1, 3);
      src.fire(SRC_LINE1, 3);
      pc(1, 1);
      till(1, 1'b1);
      t0 = cyc;
      till(1, 1'b0);
      chk("readout length", RL, cyc - t0);
      till(2, 1'b0);
      $display("test overlap off done");
      for (int i = 1; i < 5; i++) begin
         apb(1'b1, A_CTRL, cw(POL_OFF, 1'b0, 3'(i)), rq, re);
         src.fire(SRC_LINE1, 3);
         pc(0, 0);
         if (3'(i) == SRC_SOFT) apb(1'b1, A_SOFT, 32'h0000_0001, rq, re);
         else src.fire(3'(i), 3);
         pc(1, 0);
         till(2, 1'b0);
      end
      apb(1'b1, A_CTRL, 32'h0000_0000, rq, re);
      src.fire(SRC_LINE1, 3);
      pc(0, 0);
      $display("test sources done");
      apb(1'b1, A_CTRL, cw(POL_READOUT, 1'b0, SRC_LINE1), rq, re);
      src.fire(SRC_LINE1, 3);
      pc(1, 0);
      till(0, 1'b1);
      src.fire(SRC_LINE1, 3);
      pc(0, 1);
      till(1, 1'b1);
      src.fire(SRC_LINE1, 3);
      pc(1, 0);
      till(1, 1'b0);
      t0 = cyc;
      till(0, 1'b1);
      chk("gap", 1, cyc - t0 >= GAP_CYC - 1);
      till(2, 1'b0);
      $display("test readout policy done");
      apb(1'b1, A_CTRL, cw(POL_EXP_CLOSE, 1'b1, SRC_LINE1), rq, re);
      src.fire(SRC_LINE1, 3);
      pc(1, 0);
      till(1, 1'b1);
      t0 = cyc;
      src.fire(SRC_LINE1, 3);
      pc(1, 0);
      till(0, 1'b1);
      till(0, 1'b0);
      chk("aligned end", 1, (cyc - t0) inside {[RL - 2:RL + 2]});
      till(2, 1'b0);
      $display("test exposure close done");
      apb(1'b1, A_CTRL, cw(POL_READOUT, 1'b1, SRC_LINE1) | 32'h0000_0010, rq, re);
      src.fire(SRC_LINE1, 60);
      @(negedge pclk);
      chk("pulse open", 1, seq.exposure);
      t0 = cyc;
      till(0, 1'b0);
      chk("pulse close", 1, cyc - t0 <= 3);
      t0 = cyc;
      src.fire(SRC_LINE1, 3);
      pc(2, 0);
      till(0, 1'b1);
      till(0, 1'b0);
      chk("pulse stretch", 1, (cyc - t0) inside {[RL - 2:RL + 2]});
      till(2, 1'b0);
      $display("test pulse width done");
      apb(1'b1, A_DEBOUNCE, 32'h0000_0001, rq, re);
      apb(1'b1, A_CTRL, cw(POL_OFF, 1'b0, SRC_LINE1), rq, re);
      src.fire(SRC_LINE1, 3);
      pc(0, 0);
      src.fire(SRC_LINE1, 40);
      pc(1, 0);
      till(2, 1'b0);
      apb(1'b0, A_STATUS, 32'h0000_0000, rq, re);
      chk("status", 0, rq);
      apb(1'b0, A_COUNT, 32'h0000_0000, rq, re);
      chk("count", {16'(er_t), 16'(ea_t)}, rq);
      $display("test debounce done");
      results;
   end
endmodule
`default_nettype wire
